/* ebm_pkg.sv */
// ebm_pkg: constants, types and states of the external bus pin block.
// assumes one 20 MHz clock and a synchronous active-high reset elsewhere.
package ebm_pkg;

  // ----------------------------------------------------------------
  // widths and reach
  // ----------------------------------------------------------------
  localparam int ADDR_W      = 24;  // internal address width
  localparam int DATA_W      = 8;   // external data byte
  localparam int AREA_NUM    = 5;   // number of area selects
  localparam int REACH_A_W   = 24;  // 16 Mbyte window
  localparam int REACH_B_W   = 20;  // 1 Mbyte window

  // ----------------------------------------------------------------
  // port zero field positions in mode B
  // ----------------------------------------------------------------
  localparam int PZ_SMP_BIT  = 5;   // ready sample strobe
  localparam int PZ_A16_BIT  = 6;   // address bit 16
  localparam int PZ_A17_BIT  = 7;   // address bit 17

  // ----------------------------------------------------------------
  // area decode: area k spans addresses with field == k
  // ----------------------------------------------------------------
  localparam int AREA_LSB    = 17;  // lowest bit of area field
  localparam int AREA_W      = 3;   // width of area field

  // ----------------------------------------------------------------
  // idle pin levels
  // ----------------------------------------------------------------
  localparam logic [AREA_NUM-1:0] SEL_IDLE = 5'h1f;  // all deselected
  localparam logic [DATA_W-1:0]   BYTE_ZERO = 8'h00; // idle byte

  // bus cycle phases, gray along idle-addr-data-end
  typedef enum logic [1:0] {
    EBM_IDLE = 2'h0,
    EBM_ADDR = 2'h1,
    EBM_DATA = 2'h3,
    EBM_END  = 2'h2
  } ebm_state_type;

  // one access request from the processor side
  typedef struct packed {
    logic              write;  // 1 write, 0 read
    logic [ADDR_W-1:0] addr;   // byte address
    logic [DATA_W-1:0] wdata;  // byte to write
  } ebm_req_type;

endpackage : ebm_pkg

/* ebm_bus.sv */
// ebm_bus: pin side of the external bus in expansion/processor modes.
// assumes requests come from the core synchronous to MCLK_I and that
// the board resolves port wires from the output enables.
`timescale 1ns/100ps
`default_nettype none

module ebm_bus (
  input  wire logic               MCLK_I,            // 20 MHz clock
  input  wire logic               RST_I,             // sync reset
  input  wire logic               PROC_EXT_I,        // 1 expansion/cpu mode
  input  wire logic               BUS_MODE_PICK_I,   // 1 mode A, 0 mode B
  input  wire logic               REQ_VALID_I,       // access wanted
  input  wire ebm_pkg::ebm_req_type REQ_I,           // access details
  input  wire logic               RDY_I,             // 1 ready, 0 wait
  input  wire logic [7:0]         PORT_TWO_PINS_I,   // port two level
  output var  logic [7:0]         PORT_ZERO_PINS_O,  // port zero drive
  output var  logic               PORT_ZERO_OE_O,    // port zero enable
  output var  logic [7:0]         PORT_TWO_PINS_O,   // port two drive
  output var  logic               PORT_TWO_OE_O,     // port two enable
  output var  logic [7:0]         ADDR_MID_O,        // address A8-A15
  output var  logic               STROBE_N_O,        // enable / read strobe
  output var  logic               RW_WR_LOW_O,       // direction / low write
  output var  logic               BHE_WR_HIGH_N_O,   // high byte / high write
  output var  logic               ALE_O,             // address latch strobe
  output var  logic               MODE_A_O,          // mode of this cycle
  output var  logic               BUSY_O,            // cycle under way
  output var  logic               DONE_O,            // one-cycle pulse
  output var  logic [7:0]         RDATA_O            // byte read
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // clip the address to the reach of the selected mode
  function automatic logic [ebm_pkg::ADDR_W-1:0] fit_addr(
    input logic [ebm_pkg::ADDR_W-1:0] a,
    input logic                       mode_a
  );
    logic [ebm_pkg::ADDR_W-1:0] r;
    r = a;
    if (!mode_a) begin
      r[ebm_pkg::ADDR_W-1:ebm_pkg::REACH_B_W] = '0;
    end
    return r;  // mode A keeps all 24 bits
  endfunction : fit_addr

  // active-low area selects for an address
  function automatic logic [ebm_pkg::AREA_NUM-1:0] area_sel_n(
    input logic [ebm_pkg::ADDR_W-1:0] a
  );
    logic [ebm_pkg::AREA_NUM-1:0] s;
    logic [ebm_pkg::AREA_W-1:0]   f;
    s = ebm_pkg::SEL_IDLE;
    f = a[ebm_pkg::AREA_LSB +: ebm_pkg::AREA_W];
    for (int k = 0; k < ebm_pkg::AREA_NUM; k++) begin
      if (f == ebm_pkg::AREA_W'(k)) begin
        s[k] = 1'b0;
      end
    end
    return s;
  endfunction : area_sel_n

  // ----------------------------------------------------------------
  // state and request holding
  // ----------------------------------------------------------------
  ebm_pkg::ebm_state_type state_q;   // current phase
  ebm_pkg::ebm_state_type state_d;   // next phase
  ebm_pkg::ebm_req_type   req_q;     // request held for the cycle
  ebm_pkg::ebm_req_type   cur;       // request seen this clock
  logic                   mode_a_q;  // mode held for the cycle
  logic                   mode_a_c;  // mode seen this clock
  logic [ebm_pkg::ADDR_W-1:0] addr_c;  // clipped address

  // next-value copies of every pin, registered below; keeping them
  // separate from the pins costs a few nets but keeps every output
  // a plain flip-flop with no logic behind the pad
  logic [7:0] zero_d;           // port zero byte
  logic       zero_oe_d;        // port zero enable
  logic [7:0] two_d;            // port two byte
  logic       two_oe_d;         // port two enable
  logic [7:0] mid_d;            // address A8-A15
  logic       strobe_n_d;       // enable or read strobe
  logic       rw_wr_low_d;      // direction or low write strobe
  logic       bhe_wr_high_n_d;  // byte high or high write strobe
  logic       ale_d;            // latch strobe
  logic [ebm_pkg::AREA_NUM-1:0] sel_n_c;  // selects for this access
  logic                         smp_n_c;  // ready sample level

  // ----------------------------------------------------------------
  // mode and request capture
  // ----------------------------------------------------------------

  // the mode is picked only between cycles so a pin change never
  // tears a cycle in half
  always_comb begin
    if (state_q == ebm_pkg::EBM_IDLE) begin
      mode_a_c = BUS_MODE_PICK_I;
      cur      = REQ_I;
    end else begin
      mode_a_c = mode_a_q;
      cur      = req_q;
    end
    addr_c = fit_addr(cur.addr, mode_a_c);
  end

  // hold request and mode when a cycle starts
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      req_q    <= '0;
      mode_a_q <= 1'b1;
    end else if (state_q == ebm_pkg::EBM_IDLE) begin
      req_q    <= REQ_I;
      mode_a_q <= mode_a_c;
    end
  end

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------

  // address phase always precedes data; ready stretches data
  always_comb begin
    state_d = state_q;
    case (state_q)
      ebm_pkg::EBM_IDLE: begin
        // single-chip mode never starts a cycle
        if (PROC_EXT_I && REQ_VALID_I) begin
          state_d = ebm_pkg::EBM_ADDR;
        end
      end
      ebm_pkg::EBM_ADDR: begin
        state_d = ebm_pkg::EBM_DATA;
      end
      ebm_pkg::EBM_DATA: begin
        // wait states while the glue holds ready low
        if (RDY_I) begin
          state_d = ebm_pkg::EBM_END;
        end
      end
      ebm_pkg::EBM_END: begin
        state_d = ebm_pkg::EBM_IDLE;
      end
      default: begin
        state_d = ebm_pkg::EBM_IDLE;
      end
    endcase
  end

  // phase register
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      state_q <= ebm_pkg::EBM_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // pin values for the coming phase
  // ----------------------------------------------------------------

  // selects stay low through the whole access to their area
  always_comb begin
    if (state_d == ebm_pkg::EBM_IDLE) begin
      sel_n_c = ebm_pkg::SEL_IDLE;
    end else begin
      sel_n_c = area_sel_n(addr_c);
    end
    // sample strobe marks the window in which ready is looked at
    smp_n_c = !(state_d == ebm_pkg::EBM_DATA);
  end

  // all pins are computed from the next phase so that each pin is
  // a flip-flop output and lines up with state_q
  always_comb begin
    zero_d          = ebm_pkg::BYTE_ZERO;
    zero_oe_d       = 1'b0;
    two_d           = ebm_pkg::BYTE_ZERO;
    two_oe_d        = 1'b0;
    mid_d           = ebm_pkg::BYTE_ZERO;
    strobe_n_d      = 1'b1;
    rw_wr_low_d     = 1'b1;
    bhe_wr_high_n_d = 1'b1;
    ale_d           = 1'b0;
    if (PROC_EXT_I) begin
      // port zero is owned by the bus outside single-chip mode
      zero_oe_d = 1'b1;
      mid_d     = addr_c[15:8];
      if (mode_a_c) begin
        zero_d = addr_c[7:0];
      end else begin
        // mode B: selects, sample strobe and A16/A17 replace A0-A7
        zero_d[ebm_pkg::AREA_NUM-1:0] = sel_n_c;
        zero_d[ebm_pkg::PZ_SMP_BIT]   = smp_n_c;
        zero_d[ebm_pkg::PZ_A16_BIT]   = addr_c[16];
        zero_d[ebm_pkg::PZ_A17_BIT]   = addr_c[17];
      end
      case (state_d)
        ebm_pkg::EBM_ADDR: begin
          // address byte goes out under the latch strobe
          ale_d    = 1'b1;
          two_oe_d = 1'b1;
          if (mode_a_c) begin
            two_d           = addr_c[23:16];
            rw_wr_low_d     = !cur.write;
            bhe_wr_high_n_d = !addr_c[0];
          end else begin
            // mode B: low address byte shares port two with data
            two_d = addr_c[7:0];
          end
        end
        ebm_pkg::EBM_DATA: begin
          // data phase: port two drives only on writes
          two_oe_d = cur.write;
          two_d    = cur.wdata;
          if (mode_a_c) begin
            strobe_n_d      = 1'b0;
            rw_wr_low_d     = !cur.write;
            bhe_wr_high_n_d = !addr_c[0];
          end else begin
            // mode B: one strobe per direction, steered by addr[0]
            strobe_n_d      = cur.write;
            rw_wr_low_d     = !(cur.write && !addr_c[0]);
            bhe_wr_high_n_d = !(cur.write && addr_c[0]);
          end
        end
        ebm_pkg::EBM_END: begin
          // strobes released, address held one more clock
          if (mode_a_c) begin
            rw_wr_low_d     = !cur.write;
            bhe_wr_high_n_d = !addr_c[0];
          end
        end
        default: begin
          // idle: direction rests at read, strobes high
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin registers
  // ----------------------------------------------------------------

  // bus pins
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      PORT_ZERO_PINS_O <= ebm_pkg::BYTE_ZERO;
      PORT_ZERO_OE_O   <= 1'b0;
      PORT_TWO_PINS_O  <= ebm_pkg::BYTE_ZERO;
      PORT_TWO_OE_O    <= 1'b0;
      ADDR_MID_O       <= ebm_pkg::BYTE_ZERO;
      STROBE_N_O       <= 1'b1;
      RW_WR_LOW_O      <= 1'b1;
      BHE_WR_HIGH_N_O  <= 1'b1;
      ALE_O            <= 1'b0;
    end else begin
      PORT_ZERO_PINS_O <= zero_d;
      PORT_ZERO_OE_O   <= zero_oe_d;
      PORT_TWO_PINS_O  <= two_d;
      PORT_TWO_OE_O    <= two_oe_d;
      ADDR_MID_O       <= mid_d;
      STROBE_N_O       <= strobe_n_d;
      RW_WR_LOW_O      <= rw_wr_low_d;
      BHE_WR_HIGH_N_O  <= bhe_wr_high_n_d;
      ALE_O            <= ale_d;
    end
  end

  // ----------------------------------------------------------------
  // processor-side status
  // ----------------------------------------------------------------

  // busy, done pulse and mode shown to the core
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      BUSY_O   <= 1'b0;
      DONE_O   <= 1'b0;
      MODE_A_O <= 1'b1;
    end else begin
      BUSY_O   <= (state_d != ebm_pkg::EBM_IDLE);
      DONE_O   <= (state_d == ebm_pkg::EBM_END);
      MODE_A_O <= mode_a_c;
    end
  end

  // read byte is taken on the ready edge that ends the data phase;
  // limitation: the board must hold data until that edge
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      RDATA_O <= ebm_pkg::BYTE_ZERO;
    end else if (state_q == ebm_pkg::EBM_DATA && RDY_I && !req_q.write) begin
      RDATA_O <= PORT_TWO_PINS_I;
    end
  end

endmodule : ebm_bus

`default_nettype wire

/* ebm_bus_checker.sv */
// ebm_bus_checker: pin timing assertions for the external bus block.
// assumes it is bound onto ebm_bus and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none

module ebm_bus_checker (
  input wire logic                 MCLK_I,
  input wire logic                 RST_I,
  input wire logic                 PROC_EXT_I,
  input wire logic                 BUS_MODE_PICK_I,
  input wire logic                 REQ_VALID_I,
  input wire ebm_pkg::ebm_req_type REQ_I,
  input wire logic [7:0]           PORT_ZERO_PINS_O,
  input wire logic [7:0]           PORT_TWO_PINS_O,
  input wire logic                 STROBE_N_O,
  input wire logic                 RW_WR_LOW_O,
  input wire logic                 BHE_WR_HIGH_N_O,
  input wire logic                 ALE_O,
  input wire logic                 MODE_A_O,
  input wire logic                 BUSY_O,
  input wire logic                 DONE_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);

  // ---------------------------------------------------------------
  // helper: request and mode seen at the taking edge
  // ---------------------------------------------------------------
  ebm_pkg::ebm_req_type req_q;  // request of the running cycle
  logic                 pick_q; // bus-select at the taking edge
  logic [4:0]           sel_exp; // expected area selects

  // capture while idle; a busy cycle freezes what was taken
  always_ff @(posedge MCLK_I) begin
    if (REQ_VALID_I && !BUSY_O) begin
      req_q  <= REQ_I;
      pick_q <= BUS_MODE_PICK_I;
    end
  end
  // areas past four have no select line, so all stay high
  assign sel_exp = (req_q.addr[19:17] < 3'h5) ? ~(5'h01 << req_q.addr[19:17]) : 5'h1f;

  // ---------------------------------------------------------------
  // address phase sequences
  // ---------------------------------------------------------------
  sequence s_addr_a; ALE_O && MODE_A_O; endsequence
  sequence s_addr_b; ALE_O && !MODE_A_O; endsequence

  chk_pick_mode:
    assert property (ALE_O |-> MODE_A_O == pick_q) else $error("bus mode mismatch");
  chk_low_addr_a:
    assert property (s_addr_a |-> PORT_ZERO_PINS_O == req_q.addr[7:0]) else $error("port zero addr");
  chk_high_share_a:
    assert property (s_addr_a |-> PORT_TWO_PINS_O == req_q.addr[23:16]) else $error("port two hi");
  chk_low_share_b:
    assert property (s_addr_b |-> PORT_TWO_PINS_O == req_q.addr[7:0]
      && PORT_ZERO_PINS_O[7:6] == req_q.addr[17:16]) else $error("port two low addr");
  chk_area_select:
    assert property (s_addr_b |-> PORT_ZERO_PINS_O[4:0] == sel_exp) else $error("area select");
  chk_enable_a:
    assert property (s_addr_a |=> !STROBE_N_O && !ALE_O) else $error("enable strobe");
  chk_read_only_b:
    assert property (!MODE_A_O && !STROBE_N_O |-> !req_q.write && BUSY_O && !ALE_O)
      else $error("read strobe");
  chk_sample_data_b:
    assert property (s_addr_b |-> PORT_ZERO_PINS_O[5] ##1 !PORT_ZERO_PINS_O[5])
      else $error("sample strobe");
  chk_dir_a:
    assert property (s_addr_a |-> (RW_WR_LOW_O == !req_q.write) [*2]) else $error("direction");
  chk_write_b:
    assert property (!MODE_A_O && !(RW_WR_LOW_O && BHE_WR_HIGH_N_O) |-> req_q.write && !ALE_O
      && RW_WR_LOW_O == req_q.addr[0]) else $error("write strobe");
  chk_done_bound:
    assert property ($rose(ALE_O) |-> ##[2:10] DONE_O) else $error("cycle never ended");
  chk_single_idle:
    assert property (!PROC_EXT_I && !BUSY_O |=> !BUSY_O && !ALE_O) else $error("single-chip cycle");
endmodule : ebm_bus_checker

bind ebm_bus ebm_bus_checker u_chk (.MCLK_I, .RST_I, .PROC_EXT_I, .BUS_MODE_PICK_I,
  .REQ_VALID_I, .REQ_I, .PORT_ZERO_PINS_O, .PORT_TWO_PINS_O, .STROBE_N_O, .RW_WR_LOW_O,
  .BHE_WR_HIGH_N_O, .ALE_O, .MODE_A_O, .BUSY_O, .DONE_O);
`default_nettype wire

/* ebm_mem_model.sv */
// ebm_mem_model: external memory with ready glue behind the bus pins.
// assumes the bench resolves port two from the device's enable alone.
`timescale 1ns/100ps
`default_nettype none

module ebm_mem_model (
  input  wire logic       clk,
  input  wire logic       ale,
  input  wire logic       mode_a,
  input  wire logic       strobe_n,
  input  wire logic [7:0] pz,
  input  wire logic [7:0] pt,
  input  wire logic [1:0] nwait,
  output var  logic [7:0] drv,
  output var  logic       rdy
);
  logic [7:0] lo_q   = 8'h00; // latched low address byte
  logic [7:0] last_q = 8'h00; // last byte driven
  logic [2:0] cnt_q  = 3'h0;  // cycles since latch strobe

  // low byte on port zero in mode A, on port two in mode B
  always_ff @(posedge clk) if (ale) lo_q <= mode_a ? pz : pt;
  always_ff @(posedge clk) cnt_q <= ale ? 3'h0 : cnt_q + 3'h1;
  always_ff @(posedge clk) if (!strobe_n) last_q <= lo_q ^ 8'ha5;
  // released bus shows the inverse so a stale byte never matches
  assign drv = !strobe_n ? lo_q ^ 8'ha5 : ~last_q;
  // wait glue: ready held low for nwait data cycles; in mode B the glue
  // answers only while the sample strobe on port zero is low
  assign rdy = (mode_a || !pz[5]) && cnt_q >= {1'b0, nwait};
endmodule : ebm_mem_model
`default_nettype wire

/* external_bus_mode_pins_tb_top.sv */
// external_bus_mode_pins_tb_top: directed scenarios for the bus pins.
// assumes ebm_bus, its checker and the memory model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module external_bus_mode_pins_tb_top;
  logic mclk = 1'b0, rst = 1'b1, proc_ext = 1'b1, pick = 1'b1, req_valid = 1'b0;
  ebm_pkg::ebm_req_type req = '0;
  logic [7:0] pz, pt_o, pt_wire, mem_drv, mid, rdata;
  logic       pz_oe, pt_oe, strobe_n, dir_wr_low, bhe_wr_high_n, ale, mode_a, busy, done, rdy;
  logic [1:0] nwait = 2'h0;
  int         err_total = 0;
  int         num_checks = 0;

  always #25 mclk = ~mclk;
  // device enable wins the shared wire
  assign pt_wire = pt_oe ? pt_o : mem_drv;

  ebm_bus dut (.MCLK_I(mclk), .RST_I(rst), .PROC_EXT_I(proc_ext), .BUS_MODE_PICK_I(pick),
    .REQ_VALID_I(req_valid), .REQ_I(req), .RDY_I(rdy), .PORT_TWO_PINS_I(pt_wire),
    .PORT_ZERO_PINS_O(pz), .PORT_ZERO_OE_O(pz_oe), .PORT_TWO_PINS_O(pt_o),
    .PORT_TWO_OE_O(pt_oe), .ADDR_MID_O(mid), .STROBE_N_O(strobe_n),
    .RW_WR_LOW_O(dir_wr_low), .BHE_WR_HIGH_N_O(bhe_wr_high_n), .ALE_O(ale),
    .MODE_A_O(mode_a), .BUSY_O(busy), .DONE_O(done), .RDATA_O(rdata));
  ebm_mem_model mem (.clk(mclk), .ale(ale), .mode_a(mode_a), .strobe_n(strobe_n),
    .pz(pz), .pt(pt_wire), .nwait(nwait), .drv(mem_drv), .rdy(rdy));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one bus cycle, judged phase by phase
  task automatic access(input logic wr, input logic [23:0] a, input logic [7:0] wd,
                        input logic ma, input logic [1:0] nw);
    logic [7:0] sel;
    int         n;
    sel = 8'hff;
    if (a[19:17] < 3'h5) sel[a[19:17]] = 1'b0;
    sel[7:6] = a[17:16];
    n = 0;
    @(posedge mclk);
    req <= {wr, a, wd};
    pick <= ma;
    nwait <= nw;
    req_valid <= 1'b1;
    @(posedge mclk); #1;
    while (ale !== 1'b1 && n < 4) begin
      @(posedge mclk); #1;
      n++;
    end
    chk(mode_a, ma);
    chk(pt_oe, 1'b1);
    chk(pz_oe, 1'b1);
    chk(busy, 1'b1);
    if (ma) begin
      chk(pz, a[7:0]);
      chk(pt_o, a[23:16]);
      chk(mid, a[15:8]);
    end else begin
      chk(pz, sel);
      chk(pt_o, a[7:0]);
    end
    @(posedge mclk);
    req_valid <= 1'b0;
    #1;
    chk(ale, 1'b0);
    chk(pt_oe, wr);
    if (wr) chk(pt_o, wd);
    if (ma) begin
      chk(strobe_n, 1'b0);
      chk(dir_wr_low, !wr);
      chk(bhe_wr_high_n, !a[0]);
    end else begin
      chk(strobe_n, wr);
      chk(dir_wr_low, !(wr && !a[0]));
      chk(bhe_wr_high_n, !(wr && a[0]));
      chk(pz[5], 1'b0);
    end
    n = 1;
    while (done !== 1'b1 && n < 12) begin
      @(posedge mclk); #1;
      n++;
    end
    chk(8'(n), 8'(2 + nw));
    if (!wr) chk(rdata, a[7:0] ^ 8'ha5);
    chk(strobe_n, 1'b1);
    @(posedge mclk);
  endtask : access

  task automatic t_mode_a;
    access(1'b0, 24'hc3_5a7e, 8'h00, 1'b1, 2'h0);
    access(1'b1, 24'h81_2345, 8'h3c, 1'b1, 2'h1);
  endtask : t_mode_a

  task automatic t_mode_b;
    access(1'b0, 24'hf3_4567, 8'h00, 1'b0, 2'h2);
    access(1'b1, 24'h02_0aa4, 8'h96, 1'b0, 2'h0);
    access(1'b1, 24'h02_0aa5, 8'h69, 1'b0, 2'h3);
  endtask : t_mode_b

  // every area, plus the three codes that select nothing
  task automatic t_areas;
    for (int k = 0; k < 8; k++) access(1'b0, {4'h0, 3'(k), 14'h1a5a, 3'(k)}, 8'h00, 1'b0, 2'h0);
  endtask : t_areas

  // single-chip: request and bus-select levels must do nothing
  task automatic t_single;
    @(posedge mclk);
    proc_ext <= 1'b0;
    req_valid <= 1'b1;
    repeat (6) begin
      @(posedge mclk);
      pick <= !pick;
      #1;
      chk(busy, 1'b0);
      chk(ale, 1'b0);
    end
    chk(pz_oe, 1'b0);
    @(posedge mclk);
    proc_ext <= 1'b1;
    req_valid <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : t_single

  // reset in mid-cycle: the cycle is cut and every pin returns to rest
  task automatic t_reset;
    @(posedge mclk);
    req <= {1'b1, 24'h0b_5a3c, 8'h81};
    pick <= 1'b0;
    req_valid <= 1'b1;
    @(posedge mclk);
    req_valid <= 1'b0;
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk(busy, 1'b0);
    chk(ale, 1'b0);
    chk(pt_oe, 1'b0);
    chk(pz_oe, 1'b0);
    chk(strobe_n, 1'b1);
    chk(dir_wr_low, 1'b1);
    chk(bhe_wr_high_n, 1'b1);
    chk(mode_a, 1'b1);
    chk(done, 1'b0);
    chk(rdata, 8'h00);
  endtask : t_reset

  task automatic results;
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  // about 100 cycles of traffic; this leaves a wide margin
  initial begin
    #50000;
    err_total++;
    results();
  end

  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk); #1;
    chk(rdata, 8'h00);
    chk(strobe_n, 1'b1);
    t_mode_a();
    t_mode_b();
    t_areas();
    t_single();
    t_reset();
    access(1'b0, 24'h12_3401, 8'h00, 1'b1, 2'h0);
    results();
  end
endmodule : external_bus_mode_pins_tb_top
`default_nettype wire
